// File: tac_abort_cause.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Contract
// - Starting a master operation with master mode off sets the master-disabled flag.
// - A ten-bit read with restarts disabled sets the ten-bit-read-without-restart flag.
// - A start byte with restarts disabled sets the start-byte-without-restart flag.
// - Clearing the start-byte-without-restart flag while its cause stands drops it one cycle, then it returns.
// - A high-speed transfer with restarts disabled sets the high-speed-without-restart flag.
// - An acknowledged start byte sets the start-byte-acknowledged flag.
// - An acknowledged high-speed master code sets the high-speed-code-acknowledged flag.
// - A read queued after a general call sets the general-call-read flag.
// - An unacknowledged general call sets the general-call-unacknowledged flag.
// - A data byte not acknowledged after an acknowledged address sets the data-unacknowledged flag.
// - An unacknowledged second ten-bit address byte sets the second-address-byte flag.
// - An unacknowledged first ten-bit address byte sets the first-address-byte flag.
// - An unacknowledged seven-bit address sets the seven-bit-address flag.
// - Any set flag raises the transmit abort event bit.
// - Reading either clear register clears all flags, the start-byte flag only once its cause is gone.
module tac_abort_cause
    import tac_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [TAC_ADDR_W-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic [31:0]                readdata,
    output logic                       waitrequest,
    input  wire logic                  master_start,
    input  wire logic                  cmd_is_read,
    input  wire logic                  tenbit_mode,
    input  wire logic                  highspeed_mode,
    input  wire logic                  addr_phase_nack,
    input  wire logic                  addr2_phase_nack,
    input  wire logic                  data_phase_nack,
    input  wire logic                  gcall_phase_nack,
    input  wire logic                  start_byte_acked,
    input  wire logic                  hs_code_acked,
    input  wire logic                  gcall_sent,
    output logic                       transmit_abort_event_q,
    output logic                       repeated_start_enable_q,
    output logic                       master_enable_q
);
    logic [31:0]              controller_config_q;
    logic [31:0]              controller_config_d;
    logic [31:0]              target_address_config_q;
    logic [31:0]              target_address_config_d;
    logic [31:0]              readdata_d;
    logic [31:0]              readdata_q;
    logic [TAC_NUM_FLAGS-1:0] set_vec;
    logic [TAC_NUM_FLAGS-1:0] hold_vec;
    logic [TAC_NUM_FLAGS-1:0] abort_flags;
    logic                     strobe;
    logic                     restart_en;
    logic                     command_select_a_cmd;
    logic                     clear_rd;
    logic                     start_byte_cause;
    logic                     master_on;

    tac_bus u_bus (
        .clk         (clk),
        .resetn      (resetn),
        .read        (read),
        .write       (write),
        .waitrequest (waitrequest),
        .strobe_q    (strobe)
    );

    assign restart_en  = controller_config_q[TAC_CTL_RESTART_EN];
    assign master_on   = controller_config_q[TAC_CTL_MASTER_EN];
    assign command_select_a_cmd = target_address_config_q[TAC_TGT_COMMAND_SELECT_A];
    assign start_byte_cause = !restart_en && command_select_a_cmd
                            && target_address_config_q[TAC_TGT_GENERAL_CALL_OR_START_BYTE_SELECT];
    assign clear_rd = strobe && read
                    && (address == TAC_IDX_CLR_ABORT || address == TAC_IDX_CLR_ALL);

    // Cause detection; every cause but master-disabled only counts while master mode is on.
    always_comb begin
        set_vec = '0;
        hold_vec = '0;
        set_vec[TAC_BIT_MASTER_DIS]   = master_start && !master_on;
        set_vec[TAC_BIT_10B_RD_NORST] = master_start && master_on && !restart_en
                                        && tenbit_mode && cmd_is_read;
        set_vec[TAC_BIT_SB_NORST]     = master_start && master_on && start_byte_cause;
        hold_vec[TAC_BIT_SB_NORST]    = start_byte_cause;
        set_vec[TAC_BIT_HS_NORST]     = master_start && master_on && !restart_en && highspeed_mode;
        set_vec[TAC_BIT_SB_ACKED]     = master_on && start_byte_acked;
        set_vec[TAC_BIT_HS_ACKED]     = master_on && highspeed_mode && hs_code_acked;
        set_vec[TAC_BIT_GC_READ]      = master_on && gcall_sent && cmd_is_read;
        set_vec[TAC_BIT_GC_NACK]      = master_on && gcall_phase_nack;
        set_vec[TAC_BIT_DATA_NACK]    = master_on && data_phase_nack;
        set_vec[TAC_BIT_10B_ADDR2]    = master_on && tenbit_mode && addr2_phase_nack;
        set_vec[TAC_BIT_10B_ADDR1]    = master_on && tenbit_mode && addr_phase_nack;
        set_vec[TAC_BIT_7B_ADDR]      = master_on && !tenbit_mode && addr_phase_nack;
    end

    genvar gi;
    generate
        for (gi = 0; gi < TAC_NUM_FLAGS; gi++) begin : g_flag
            tac_flag u_flag (
                .clk      (clk),
                .resetn   (resetn),
                .set_in   (set_vec[gi]),
                .clear_in (clear_rd),
                .hold_in  (hold_vec[gi]),
                .flag_q   (abort_flags[gi])
            );
        end
    endgenerate

    // Configuration writes honour byte enables; the abort register ignores writes.
    always_comb begin
        controller_config_d     = controller_config_q;
        target_address_config_d = target_address_config_q;
        if (strobe && write) begin
            for (int b = 0; b < 4; b++) begin
                if (byteenable[b]) begin
                    if (address == TAC_IDX_CONTROL) begin
                        controller_config_d[b*8 +: 8] = writedata[b*8 +: 8];
                    end
                    if (address == TAC_IDX_TARGET) begin
                        target_address_config_d[b*8 +: 8] = writedata[b*8 +: 8];
                    end
                end
            end
        end
    end

    always_comb begin
        readdata_d = TAC_ZERO_WORD;
        if (read && waitrequest) begin
            case (address)
                TAC_IDX_ABORT_CAUSE: readdata_d = {20'h0_0000, abort_flags};
                TAC_IDX_CLR_ABORT:   readdata_d = {31'h0000_0000, transmit_abort_event_q};
                TAC_IDX_CLR_ALL:     readdata_d = {31'h0000_0000, transmit_abort_event_q};
                TAC_IDX_CONTROL:     readdata_d = controller_config_q;
                TAC_IDX_TARGET:      readdata_d = target_address_config_q;
                TAC_IDX_PENDING:     readdata_d = {31'h0000_0000, transmit_abort_event_q};
                default:             readdata_d = TAC_ZERO_WORD;
            endcase
        end else begin
            readdata_d = readdata_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            controller_config_q     <= TAC_CONTROL_RESET;
            target_address_config_q <= TAC_TARGET_RESET;
            readdata_q              <= TAC_ZERO_WORD;
            transmit_abort_event_q  <= 1'b0;
            repeated_start_enable_q <= TAC_CONTROL_RESET[TAC_CTL_RESTART_EN];
            master_enable_q         <= TAC_CONTROL_RESET[TAC_CTL_MASTER_EN];
        end else begin
            controller_config_q     <= controller_config_d;
            target_address_config_q <= target_address_config_d;
            readdata_q              <= readdata_d;
            transmit_abort_event_q  <= |abort_flags;
            repeated_start_enable_q <= controller_config_d[TAC_CTL_RESTART_EN];
            master_enable_q         <= controller_config_d[TAC_CTL_MASTER_EN];
        end
    end

    assign readdata = readdata_q;

    a_master_dis_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_start && !master_on) |=> abort_flags[TAC_BIT_MASTER_DIS])
        else $error("master disabled abort not set");
    a_tenbit_rd_set: assert property (@(posedge clk) disable iff (!resetn)
        set_vec[TAC_BIT_10B_RD_NORST] |=> abort_flags[TAC_BIT_10B_RD_NORST])
        else $error("ten-bit read abort not set");

    a_sbyte_hold_back: assert property (@(posedge clk) disable iff (!resetn)
        (clear_rd && start_byte_cause && abort_flags[TAC_BIT_SB_NORST] && !set_vec[TAC_BIT_SB_NORST])
        ##1 start_byte_cause |-> !abort_flags[TAC_BIT_SB_NORST] ##1 abort_flags[TAC_BIT_SB_NORST])
        else $error("start byte flag did not drop then return");

    a_sbyte_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_start && master_on && start_byte_cause) |=> abort_flags[TAC_BIT_SB_NORST])
        else $error("start byte abort not set");

    a_addr7_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && !tenbit_mode && addr_phase_nack && !abort_flags[TAC_BIT_10B_ADDR1])
        |=> abort_flags[TAC_BIT_7B_ADDR] && !abort_flags[TAC_BIT_10B_ADDR1])
        else $error("seven-bit nack flag wrong");

    a_addr10_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && tenbit_mode && addr_phase_nack && !$past(abort_flags[TAC_BIT_7B_ADDR])) |=> abort_flags[TAC_BIT_10B_ADDR1])
        else $error("ten-bit first byte flag not set");
    a_event_follows: assert property (@(posedge clk) disable iff (!resetn)
        (|abort_flags) |=> transmit_abort_event_q)
        else $error("abort event not raised");
    a_clear_works: assert property (@(posedge clk) disable iff (!resetn)
        (clear_rd && set_vec == '0 && !start_byte_cause) |=> abort_flags == '0)
        else $error("clear read left flags set");
    a_flags_quiet: assert property (@(posedge clk) disable iff (!resetn)
        ($past(abort_flags) == '0 && $past(set_vec) == '0 && $past(hold_vec) == '0) |-> abort_flags == '0)
        else $error("flag rose without cause");
    a_data_nack_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && data_phase_nack) |=> abort_flags[TAC_BIT_DATA_NACK])
        else $error("data nack flag not set");


    a_hs_norst_set: assert property (@(posedge clk) disable iff (!resetn)
        set_vec[TAC_BIT_HS_NORST] |=> abort_flags[TAC_BIT_HS_NORST])
        else $error("high-speed without restart abort not set");

    a_sb_acked_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && start_byte_acked) |=> abort_flags[TAC_BIT_SB_ACKED])
        else $error("start byte acked abort not set");

    a_hs_acked_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && highspeed_mode && hs_code_acked) |=> abort_flags[TAC_BIT_HS_ACKED])
        else $error("high-speed code acked abort not set");

    a_hs_acked_needs_hs: assert property (@(posedge clk) disable iff (!resetn)
        (hs_code_acked && !highspeed_mode && !abort_flags[TAC_BIT_HS_ACKED]) |=> !abort_flags[TAC_BIT_HS_ACKED])
        else $error("high-speed code acked abort set outside high-speed mode");

    a_gc_read_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && gcall_sent && cmd_is_read) |=> abort_flags[TAC_BIT_GC_READ])
        else $error("general call read abort not set");

    a_gc_read_needs_read: assert property (@(posedge clk) disable iff (!resetn)
        (gcall_sent && !cmd_is_read && !abort_flags[TAC_BIT_GC_READ]) |=> !abort_flags[TAC_BIT_GC_READ])
        else $error("general call read abort set without a read");

    a_gc_nack_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && gcall_phase_nack) |=> abort_flags[TAC_BIT_GC_NACK])
        else $error("general call nack abort not set");

    a_addr2_set: assert property (@(posedge clk) disable iff (!resetn)
        (master_on && tenbit_mode && addr2_phase_nack) |=> abort_flags[TAC_BIT_10B_ADDR2])
        else $error("second address byte abort not set");

    a_others_clear: assert property (@(posedge clk) disable iff (!resetn)
        (clear_rd && set_vec == '0) |=> (abort_flags & ~(12'(1 << TAC_BIT_SB_NORST))) == '0)
        else $error("clear read left a flag set");

    a_sbyte_fixed_clears: assert property (@(posedge clk) disable iff (!resetn)
        (clear_rd && !start_byte_cause && !set_vec[TAC_BIT_SB_NORST]) |=> !abort_flags[TAC_BIT_SB_NORST])
        else $error("start byte flag kept after its cause was fixed");

    a_event_drops: assert property (@(posedge clk) disable iff (!resetn)
        (abort_flags == '0) |=> !transmit_abort_event_q)
        else $error("abort event raised without a flag");

    a_cause_readonly: assert property (@(posedge clk) disable iff (!resetn)
        (strobe && write && set_vec == '0 && hold_vec == '0) |=> $stable(abort_flags))
        else $error("a write changed the abort flags");

    a_cause_readback: assert property (@(posedge clk) disable iff (!resetn)
        (read && waitrequest && address == TAC_IDX_ABORT_CAUSE) |=> readdata == {20'h0_0000, $past(abort_flags)})
        else $error("abort cause read back wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
        (read && waitrequest && address > TAC_IDX_PENDING) |=> readdata == TAC_ZERO_WORD)
        else $error("unmapped read not zero");

    a_pending_read: assert property (@(posedge clk) disable iff (!resetn)
        (read && waitrequest && address == TAC_IDX_PENDING) |=> readdata == {31'h0000_0000, $past(transmit_abort_event_q)})
        else $error("pending event read back wrong");

    a_clear_read_event: assert property (@(posedge clk) disable iff (!resetn)
        (read && waitrequest && (address == TAC_IDX_CLR_ABORT || address == TAC_IDX_CLR_ALL))
        |=> readdata == {31'h0000_0000, $past(transmit_abort_event_q)})
        else $error("clear register read back wrong");

    a_master_en_write: assert property (@(posedge clk) disable iff (!resetn)
        (strobe && write && address == TAC_IDX_CONTROL && byteenable[0])
        |=> master_on == $past(writedata[TAC_CTL_MASTER_EN]))
        else $error("master enable write lost");

    a_byte_lane_skip: assert property (@(posedge clk) disable iff (!resetn)
        (strobe && write && address == TAC_IDX_CONTROL && !byteenable[0]) |=> $stable(master_on))
        else $error("disabled byte lane changed master enable");

    a_restart_write: assert property (@(posedge clk) disable iff (!resetn)
        (strobe && write && address == TAC_IDX_CONTROL && byteenable[0])
        |=> restart_en == $past(writedata[TAC_CTL_RESTART_EN]))
        else $error("restart enable write lost");

    a_command_select_a_write: assert property (@(posedge clk) disable iff (!resetn)
        (strobe && write && address == TAC_IDX_TARGET && byteenable[1])
        |=> command_select_a_cmd == $past(writedata[TAC_TGT_COMMAND_SELECT_A]))
        else $error("command_select_a command write lost");

    a_master_dis_only: assert property (@(posedge clk) disable iff (!resetn)
        (master_start && !master_on && abort_flags == '0 && !start_byte_cause)
        |=> abort_flags == 12'(1 << TAC_BIT_MASTER_DIS))
        else $error("master disabled start raised another flag");

    a_wait_single: assert property (@(posedge clk) disable iff (!resetn)
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    c_clear_read: cover property (@(posedge clk) disable iff (!resetn) clear_rd && |abort_flags);

    c_tenbit_rd: cover property (@(posedge clk) disable iff (!resetn) set_vec[TAC_BIT_10B_RD_NORST]);

    c_master_dis: cover property (@(posedge clk) disable iff (!resetn) set_vec[TAC_BIT_MASTER_DIS]);

    c_sbyte_return: cover property (@(posedge clk) disable iff (!resetn)
        clear_rd && start_byte_cause ##2 abort_flags[TAC_BIT_SB_NORST]);
    c_gcall_read: cover property (@(posedge clk) disable iff (!resetn) set_vec[TAC_BIT_GC_READ]);
endmodule

// File: tac_abort_cause_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tac_abort_cause_bench
    import tac_pkg::*;
;
    logic clk = 0, resetn = 0, read = 0, write = 0, master_start = 0, cmd_is_read = 0, fire = 0;
    logic tenbit_mode = 0, highspeed_mode = 0, waitrequest, transmit_abort_event_q;
    logic repeated_start_enable_q, master_enable_q;
    logic [TAC_ADDR_W-1:0] address = '0;
    logic [31:0] writedata = '0, readdata, rd_q, lfsr_q = 32'h01bb_82b0;
    logic [3:0]  byteenable = 4'hf;
    logic [2:0]  kind = '0;
    logic [1:0]  lag = '0;
    logic [7:0]  pulse_q;
    int failures = 0, compares = 0, exp_flags = 0;
    int bit_of[8] = '{0, 1, 2, 3, 4, 7, 6, 5};
    always #5 clk = ~clk;
    tac_abort_cause tac_abort_cause_inst (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .master_start(master_start), .cmd_is_read(cmd_is_read),
        .tenbit_mode(tenbit_mode), .highspeed_mode(highspeed_mode), .addr_phase_nack(pulse_q[0] | pulse_q[1]),
        .addr2_phase_nack(pulse_q[2]), .data_phase_nack(pulse_q[3]), .gcall_phase_nack(pulse_q[4]),
        .start_byte_acked(pulse_q[5]), .hs_code_acked(pulse_q[6]), .gcall_sent(pulse_q[7]),
        .transmit_abort_event_q(transmit_abort_event_q), .repeated_start_enable_q(repeated_start_enable_q),
        .master_enable_q(master_enable_q));
    tac_target_model tac_target_model_inst (.clk(clk), .resetn(resetn), .fire(fire), .kind(kind), .lag(lag),
        .pulse_q(pulse_q));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        `CHK(waitrequest, 1'b0)
        rd_q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse_start();
        master_start <= 1'b1;
        @(posedge clk);
        master_start <= 1'b0;
    endtask
    task automatic cause_done(input int b);
        repeat (6) @(posedge clk);
        exp_flags = exp_flags | (1 << b);
        bus(0, TAC_IDX_ABORT_CAUSE, '0);
        `CHK(rd_q, 32'(exp_flags))
        `CHK(transmit_abort_event_q, 1'b1)
        $display("test flag %0d done", b);
    endtask
    task automatic clear_check(input logic [3:0] idx, input logic cause_stands);
        bus(0, idx, '0);
        `CHK(rd_q, {31'h0, exp_flags != 0})
        exp_flags = cause_stands ? (exp_flags & 32'h0000_0200) : 0;
        repeat (3) @(posedge clk);
        bus(0, TAC_IDX_ABORT_CAUSE, '0);
        `CHK(rd_q, 32'(exp_flags))
        `CHK(transmit_abort_event_q, exp_flags != 0)
    endtask
    task automatic summarize();
        $display("counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(0, TAC_IDX_ABORT_CAUSE, '0);
        `CHK(rd_q, TAC_ZERO_WORD)
        lfsr_q = lfsr_next(lfsr_q);
        bus(1, TAC_IDX_ABORT_CAUSE, lfsr_q);
        bus(0, TAC_IDX_ABORT_CAUSE, '0);
        `CHK(rd_q, TAC_ZERO_WORD)
        bus(0, 4'hf, '0);
        `CHK(rd_q, TAC_ZERO_WORD)
        bus(0, TAC_IDX_CONTROL, '0);
        `CHK(rd_q, TAC_CONTROL_RESET)
        `CHK(master_enable_q, 1'b1)
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            tenbit_mode <= (k == 1 || k == 2);
            highspeed_mode <= (k == 6);
            cmd_is_read <= (k == 7);
            kind <= 3'(k);
            lag <= lfsr_q[1:0];
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            cause_done(bit_of[k]);
            clear_check(k[0] ? TAC_IDX_CLR_ABORT : TAC_IDX_CLR_ALL, 1'b0);
        end
        bus(1, TAC_IDX_CONTROL, 32'h0000_0001);
        `CHK(repeated_start_enable_q, 1'b0)
        for (int s = 0; s < 2; s++) begin
            tenbit_mode <= (s == 0);
            cmd_is_read <= (s == 0);
            highspeed_mode <= (s == 1);
            pulse_start();
            cause_done(s == 0 ? 10 : 8);
            clear_check(TAC_IDX_CLR_ALL, 1'b0);
        end
        tenbit_mode <= 1'b0;
        cmd_is_read <= 1'b0;
        highspeed_mode <= 1'b0;
        bus(1, TAC_IDX_TARGET, 32'h0000_0c00);
        pulse_start();
        cause_done(9);
        clear_check(TAC_IDX_CLR_ALL, 1'b1);
        bus(1, TAC_IDX_CONTROL, 32'h0000_0021);
        clear_check(TAC_IDX_CLR_ABORT, 1'b0);
        bus(1, TAC_IDX_CONTROL, 32'h0000_0020);
        `CHK(master_enable_q, 1'b0)
        pulse_start();
        cause_done(11);
        clear_check(TAC_IDX_CLR_ALL, 1'b0);
        summarize();
    end
endmodule

// File: tac_bus.sv
`timescale 1ns/1ns
module tac_bus
    import tac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        read,
    input  wire logic        write,
    output logic             waitrequest,
    output logic             strobe_q
);
    tac_bus_state_type state_q;
    tac_bus_state_type state_d;

    // One wait cycle, then a single-cycle strobe releases the request.
    always_comb begin
        case (state_q)
            TAC_BUS_IDLE: state_d = (read || write) ? TAC_BUS_ACK : TAC_BUS_IDLE;
            TAC_BUS_ACK:  state_d = TAC_BUS_IDLE;
            default:      state_d = TAC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q     <= TAC_BUS_IDLE;
            strobe_q    <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            state_q     <= state_d;
            strobe_q    <= (state_d == TAC_BUS_ACK);
            waitrequest <= (state_d != TAC_BUS_ACK);
        end
    end
endmodule

// File: tac_flag.sv
`timescale 1ns/1ns
module tac_flag
    import tac_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic set_in,
    input  wire logic clear_in,
    input  wire logic hold_in,
    output logic      flag_q
);
    logic flag_d;
    logic rearm_q;
    logic rearm_d;

    // A set in the clear cycle wins; clearing a set flag while its hold stands drops it one cycle, then re-asserts it.
    // The hold alone never raises a flag that was not set, so a standing cause is not mistaken for an abort.
    always_comb begin
        flag_d  = flag_q;
        rearm_d = 1'b0;
        if (clear_in) begin
            flag_d  = 1'b0;
            rearm_d = hold_in && flag_q;
        end
        if (set_in || (rearm_q && hold_in)) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_q  <= 1'b0;
            rearm_q <= 1'b0;
        end else begin
            flag_q  <= flag_d;
            rearm_q <= rearm_d;
        end
    end
endmodule

// File: tac_pkg.sv
package tac_pkg;
    localparam int          TAC_ADDR_W          = 4;
    localparam int          TAC_NUM_FLAGS       = 12;
    // Word index times four gives the byte address on the bus.
    localparam logic [3:0]  TAC_IDX_ABORT_CAUSE = 4'h0;
    localparam logic [3:0]  TAC_IDX_CLR_ABORT   = 4'h1;
    localparam logic [3:0]  TAC_IDX_CLR_ALL     = 4'h2;
    localparam logic [3:0]  TAC_IDX_CONTROL     = 4'h3;
    localparam logic [3:0]  TAC_IDX_TARGET      = 4'h4;
    localparam logic [3:0]  TAC_IDX_PENDING     = 4'h5;
    // Abort cause flag positions.
    localparam int          TAC_BIT_7B_ADDR     = 0;
    localparam int          TAC_BIT_10B_ADDR1   = 1;
    localparam int          TAC_BIT_10B_ADDR2   = 2;
    localparam int          TAC_BIT_DATA_NACK   = 3;
    localparam int          TAC_BIT_GC_NACK     = 4;
    localparam int          TAC_BIT_GC_READ     = 5;
    localparam int          TAC_BIT_HS_ACKED    = 6;
    localparam int          TAC_BIT_SB_ACKED    = 7;
    localparam int          TAC_BIT_HS_NORST    = 8;
    localparam int          TAC_BIT_SB_NORST    = 9;
    localparam int          TAC_BIT_10B_RD_NORST = 10;
    localparam int          TAC_BIT_MASTER_DIS  = 11;
    // Control register fields.
    localparam int          TAC_CTL_MASTER_EN   = 0;
    localparam int          TAC_CTL_RESTART_EN  = 5;
    // Target register fields.
    localparam int          TAC_TGT_GENERAL_CALL_OR_START_BYTE_SELECT = 10;
    localparam int          TAC_TGT_COMMAND_SELECT_A     = 11;
    localparam logic [31:0] TAC_CONTROL_RESET   = 32'h0000_0021;
    localparam logic [31:0] TAC_TARGET_RESET    = 32'h0000_0000;
    localparam logic [31:0] TAC_ZERO_WORD       = 32'h0000_0000;
    localparam logic [11:0] TAC_FLAGS_RESET     = 12'h000;
    typedef enum logic [1:0] {
        TAC_BUS_IDLE = 2'b00,
        TAC_BUS_ACK  = 2'b01
    } tac_bus_state_type;
endpackage

// File: tac_target_model.sv
`timescale 1ns/1ns
module tac_target_model
    import tac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       fire,
    input  wire logic [2:0] kind,
    input  wire logic [1:0] lag,
    output logic [7:0]      pulse_q
);
    // Remote targets report the outcome of one bus phase after a chosen lag; bit k of the pulse is outcome k.
    logic       armed_q;
    logic       armed_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [2:0] kind_q;
    logic [2:0] kind_d;
    logic [7:0] pulse_d;
    always_comb begin
        armed_d = armed_q;
        cnt_d = cnt_q;
        kind_d = kind_q;
        pulse_d = 8'h00;
        if (fire) begin
            armed_d = 1'b1;
            cnt_d = lag;
            kind_d = kind;
        end else if (armed_q && cnt_q == 2'h0) begin
            armed_d = 1'b0;
            pulse_d[kind_q] = 1'b1;
        end else if (armed_q) begin
            cnt_d = cnt_q - 2'h1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
            cnt_q <= 2'h0;
            kind_q <= 3'h0;
            pulse_q <= 8'h00;
        end else begin
            armed_q <= armed_d;
            cnt_q <= cnt_d;
            kind_q <= kind_d;
            pulse_q <= pulse_d;
        end
    end
endmodule
